//--- pkg/ddr_burst4_pkg.sv
/*
 Shared constants of the four-word-burst double-data-rate SRAM port.
 Assumes the port is sampled by one fast system clock that runs well above the link clock.
*/
package ddr_burst4_pkg;
	// Data organisation
	localparam int LANE_W = 9;
	localparam int DATA_W_DEFAULT = 18;
	localparam int ADDR_W_DEFAULT = 6;
	localparam int BURST_LEN = 4;
	localparam int BEAT_W = 2;
	// Burst word positions, sequential within a burst
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_SECOND = 2'h1;
	localparam logic [1:0] BEAT_THIRD = 2'h2;
	localparam logic [1:0] BEAT_FOURTH = 2'h3;
	// Values after reset
	localparam logic RST_OE = 1'b0;
	localparam logic RST_VALID = 1'b0;
	localparam logic RST_STAGE = 1'b0;
	// Link clocks, selects and byte selects idle high, so their synchronisers reset high
	localparam logic RST_PIN_IDLE = 1'h1;
	// Depth of a pin synchroniser, in flip-flops
	localparam int SYNC_STAGES = 2;
endpackage

//--- logic/pin_sync.sv
/*
 Two flip-flop synchroniser for a group of pin inputs.
 Assumes the pins change with no relation to mclk; only the second stage is read outside.
 The reset level is chosen per group, so an idle-high pin shows no edge at release.
*/
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Pins in, synchronised copy out
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] firstStage;

	// A synchroniser of no bits has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least 1");
	end

	// Two stages; first stage feeds the second only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			firstStage <= RESET_VALUE;
			pinOut <= RESET_VALUE;
		end else begin
			firstStage <= pinIn;
			pinOut <= firstStage;
		end
	end
endmodule // pin_sync

//--- logic/ddr_burst4_sram_port.sv
/*
 Command and data port of a separate-port, double-data-rate, four-word-burst SRAM, with its array.
 Assumes the true and complementary link clocks arrive as pins, run well below mclk, and that
 every other pin is stable around their rising edges; all pins are oversampled by mclk.
*/
// What this block does
// - Write starts on select low at true rise; data on both rises of next two cycles.
// - Read starts on select low at true rise; four words return after two cycles.
// - Reset leaves the outputs undriven; both selects high start nothing.
// - Stopped clocks produce no edges, so every output keeps its state.
// - Burst words go to the latched location, then the next three within the burst.
// - A second read, or second write, on consecutive true rises is dropped.
// - A select used on the previous rise is ignored, freeing the other port.
// - Narrow width: select 0 guards bits 8:0, select 1 bits 17:9.
// - Wide width: four selects guard the four 9-bit lanes.
// - All selects high on a beat writes nothing for that beat.
// - Byte selects are taken fresh with every beat on either edge.
// - Both selects low: read unless a read started on the previous rise.
// - Valid flag rises half a cycle ahead of the first read word.
`timescale 1ns/100ps
module ddr_burst4_sram_port #(
	parameter int DATA_W = ddr_burst4_pkg::DATA_W_DEFAULT,
	parameter int ADDR_W = ddr_burst4_pkg::ADDR_W_DEFAULT
) (
	// System clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Link clock pins
	input wire logic kClk,
	input wire logic kClkN,
	// Command pins
	input wire logic readPortSelectN,
	input wire logic writePortSelectN,
	input wire logic [ADDR_W-1:0] addr,
	// Write data pins
	input wire logic [DATA_W-1:0] writeData,
	input wire logic [DATA_W/ddr_burst4_pkg::LANE_W-1:0] byteWriteSelectN,
	// Read data pins
	output logic [DATA_W-1:0] readData,
	output logic readDataOe,
	output logic readValidFlag
);
	localparam int LANES = DATA_W / ddr_burst4_pkg::LANE_W;
	localparam int IDX_W = ADDR_W + ddr_burst4_pkg::BEAT_W;
	localparam int DEPTH = 1 << IDX_W;

	// Only the two documented widths have a byte select encoding
	generate
		if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
			$error("DATA_W must be 18 or 36");
		end
		if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
			$error("ADDR_W must lie between 1 and 16");
		end
		if ((1 << ddr_burst4_pkg::BEAT_W) != ddr_burst4_pkg::BURST_LEN) begin : g_bad_burst
			$error("BEAT_W must index exactly BURST_LEN words");
		end
	endgenerate

	logic [1:0] clkSync;
	logic [1:0] clkPrev;
	logic [1:0] selSync;
	logic [ADDR_W-1:0] addrSync;
	logic [DATA_W-1:0] dataSync;
	logic [LANES-1:0] bwsSync;

	// Every pin passes two flip-flops; equal delay keeps data aligned with the clock edges
	// Clocks and selects reset high, so release shows neither a false rise nor a start
	pin_sync #(
		.WIDTH(2),
		.RESET_VALUE({2{ddr_burst4_pkg::RST_PIN_IDLE}})
	) u_sync_clk (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn({kClkN, kClk}),
		.pinOut(clkSync)
	);
	pin_sync #(
		.WIDTH(2),
		.RESET_VALUE({2{ddr_burst4_pkg::RST_PIN_IDLE}})
	) u_sync_sel (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn({writePortSelectN, readPortSelectN}),
		.pinOut(selSync)
	);
	// Address and data mean nothing until a start, so they reset low
	pin_sync #(.WIDTH(ADDR_W)) u_sync_addr (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn(addr),
		.pinOut(addrSync)
	);
	pin_sync #(.WIDTH(DATA_W)) u_sync_data (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn(writeData),
		.pinOut(dataSync)
	);
	// Byte selects reset high, like a beat that writes nothing
	pin_sync #(
		.WIDTH(LANES),
		.RESET_VALUE({LANES{ddr_burst4_pkg::RST_PIN_IDLE}})
	) u_sync_bws (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.pinIn(byteWriteSelectN),
		.pinOut(bwsSync)
	);

	// Previous clock levels; start high so a parked-high clock gives no false edge
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clkPrev <= 2'h3;
		end else begin
			clkPrev <= clkSync;
		end
	end

	// Edge events; no edges while the clocks stand still
	wire kRise = clkSync[0] & ~clkPrev[0];
	wire kbRise = clkSync[1] & ~clkPrev[1];
	wire readSel = ~selSync[0];
	wire writeSel = ~selSync[1];

	// Stage flags count true rises since a start: stage 1 is the start rise
	logic rdS1, rdS2, rdS3, rdS4;
	logic [ADDR_W-1:0] rdA1, rdA2, rdA3, rdA4;
	logic wrS1, wrS2, wrS3;
	logic [ADDR_W-1:0] wrA1, wrA2, wrA3;

	// Arbitration: a repeat of the previous start type is dropped, the other port may go
	wire readGo = readSel & ~rdS1;
	wire writeGo = writeSel & ~wrS1 & ~readGo;

	// Start pipelines advance on each true rise only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			{rdS1, rdS2, rdS3, rdS4} <= {4{ddr_burst4_pkg::RST_STAGE}};
			{wrS1, wrS2, wrS3} <= {3{ddr_burst4_pkg::RST_STAGE}};
		end else if (kRise) begin
			{rdS1, rdS2, rdS3, rdS4} <= {readGo, rdS1, rdS2, rdS3};
			{wrS1, wrS2, wrS3} <= {writeGo, wrS1, wrS2};
		end
	end

	// Latched locations follow their starts
	always_ff @(posedge mclk) begin
		if (kRise) begin
			rdA1 <= addrSync;
			rdA2 <= rdA1;
			rdA3 <= rdA2;
			rdA4 <= rdA3;
			wrA1 <= addrSync;
			wrA2 <= wrA1;
			wrA3 <= wrA2;
		end
	end

	// Write beat: true rise of t+1 and t+2 take first and third, complement rises second and fourth
	wire wrBeatK = kRise & (wrS1 | wrS2);
	wire wrBeatKb = kbRise & (wrS2 | wrS3);
	wire wrBeat = wrBeatK | wrBeatKb;
	wire [1:0] wrBeatNum = wrBeatK ? (wrS1 ? ddr_burst4_pkg::BEAT_FIRST : ddr_burst4_pkg::BEAT_THIRD)
		: (wrS2 ? ddr_burst4_pkg::BEAT_SECOND : ddr_burst4_pkg::BEAT_FOURTH);
	wire [ADDR_W-1:0] wrBase = wrBeatK ? (wrS1 ? wrA1 : wrA2) : (wrS2 ? wrA2 : wrA3);
	wire [IDX_W-1:0] wrIdx = {wrBase, wrBeatNum};

	// Read beat: first and third on true rises of t+2 and t+3, second and fourth on complement rises
	wire rdBeatK = kRise & (rdS2 | rdS3);
	wire rdBeatKb = kbRise & (rdS3 | rdS4);
	wire [1:0] rdBeatNum = rdBeatK ? (rdS2 ? ddr_burst4_pkg::BEAT_FIRST : ddr_burst4_pkg::BEAT_THIRD)
		: (rdS3 ? ddr_burst4_pkg::BEAT_SECOND : ddr_burst4_pkg::BEAT_FOURTH);
	wire [ADDR_W-1:0] rdBase = rdBeatK ? (rdS2 ? rdA2 : rdA3) : (rdS3 ? rdA3 : rdA4);
	wire [IDX_W-1:0] rdIdx = {rdBase, rdBeatNum};

	// Storage array in flip-flops
	logic [DATA_W-1:0] mem [DEPTH];
	wire [DATA_W-1:0] oldWord = mem[wrIdx];
	wire [DATA_W-1:0] rdWord = mem[rdIdx];
	logic [DATA_W-1:0] mergedWord;

	// Per-lane merge: a lane with its select high keeps the stored bits
	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			assign mergedWord[lane*ddr_burst4_pkg::LANE_W +: ddr_burst4_pkg::LANE_W] = bwsSync[lane]
				? oldWord[lane*ddr_burst4_pkg::LANE_W +: ddr_burst4_pkg::LANE_W]
				: dataSync[lane*ddr_burst4_pkg::LANE_W +: ddr_burst4_pkg::LANE_W];
		end
	endgenerate

	wire anyLane = ~&bwsSync;

	// Each beat lands in the array at once, so later reads see it
	always_ff @(posedge mclk) begin
		if (wrBeat && anyLane) begin
			mem[wrIdx] <= mergedWord;
		end
	end

	// Valid flag leads data by one edge; stages 2 and 3 span a burst on either edge type
	wire next_valid = rdS2 | rdS3;
	wire validEdge = kRise | kbRise;
	// Undrive only on a true rise with nothing to send
	wire next_oe = rdBeatK | rdBeatKb | (kbRise & readDataOe);

	// Read outputs change on link edges only and hold otherwise
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			readDataOe <= ddr_burst4_pkg::RST_OE;
			readValidFlag <= ddr_burst4_pkg::RST_VALID;
			readData <= '0;
		end else begin
			if (validEdge) begin
				readValidFlag <= next_valid;
				readDataOe <= next_oe;
			end
			if (rdBeatK || rdBeatKb) begin
				readData <= rdWord;
			end
		end
	end
endmodule // ddr_burst4_sram_port

//--- testbench/ddr_burst4_sram_port_checker.sv
/*
 Port checker for the burst SRAM port.
 Assumes the link clock pins run far below mclk.
*/
`timescale 1ns/100ps
module ddr_burst4_sram_port_checker #(
	parameter int DATA_W = 18
) (
	// Clock, reset, link pins
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic kClk,
	input wire logic kClkN,
	// Read outputs
	input wire logic [DATA_W-1:0] readData,
	input wire logic readDataOe,
	input wire logic readValidFlag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [3:0] quiet;
	// Cycles since a link pin last moved
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) quiet <= 4'h0;
		else if ($changed(kClk) || $changed(kClkN)) quiet <= 4'h0;
		else if (quiet != 4'hF) quiet <= quiet + 4'h1;
	end
	AST_OE_RST: assert property ($fell(sys_rst) |-> !readDataOe && !readValidFlag)
		else $error("live at reset");
	AST_FREEZE: assert property (quiet > 4'h7 |-> $stable(readData) && $stable(readDataOe)
		&& $stable(readValidFlag)) else $error("output moved");
	AST_VLD_FIRST: assert property ($rose(readDataOe) |-> $past(readValidFlag, 5))
		else $error("valid late");
	AST_OE_HOLD: assert property ($rose(readDataOe) |-> readDataOe[*8]) else $error("burst cut");
	AST_VLD_LEN: assert property ($rose(readValidFlag) |-> readValidFlag[*8]) else $error("valid short");
	AST_IDLE_BUS: assert property (!readDataOe |=> $stable(readData) || readDataOe)
		else $error("idle data");
	AST_OE_END: assert property ($fell(readDataOe) |-> !readValidFlag) else $error("valid stuck");
	AST_VLD_END: assert property ($fell(readValidFlag) |-> readDataOe) else $error("oe early");
endmodule // ddr_burst4_sram_port_checker
bind ddr_burst4_sram_port ddr_burst4_sram_port_checker #(.DATA_W(DATA_W)) u_ddr_burst4_sram_port_checker (
	.mclk, .sys_rst, .kClk, .kClkN, .readData, .readDataOe, .readValidFlag);

//--- testbench/link_clock_model.sv
/*
 Link clock source in place of the memory controller.
 Assumes mclk runs far above the link; HALF is each half in mclk cycles.
*/
`timescale 1ns/100ps
module link_clock_model #(
	parameter int HALF = 10
) (
	// System clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Link clock pair and its phase
	output logic kClk,
	output logic kClkN,
	output int phase
);
	// Phase counter, moved just after mclk
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) phase <= 0;
		else phase <= #1 (phase + 1) % (2 * HALF);
	end
	// True high at reset, so no edge at release
	assign kClk = phase < HALF;
	assign kClkN = !kClk;
endmodule // link_clock_model

//--- testbench/test_ddr_burst4_sram_port.sv
/*
 Bench for the burst SRAM port: mixed reads and writes on one burst location.
 Assumes the link clock model with a 10 mclk half period.
*/
`timescale 1ns/100ps
module test_ddr_burst4_sram_port;
	logic mclk = 0;
	logic sys_rst = 1;
	logic kClk, kClkN, readDataOe, readValidFlag;
	logic readPortSelectN = 1, writePortSelectN = 1;
	logic [5:0] addr = 6'h3F;
	logic [17:0] writeData = 18'h00000, readData;
	logic [1:0] byteWriteSelectN = 2'h3;
	logic [1:0] bt[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
	logic [17:0] obs[18];
	logic oeSeen[18], vldSeen[18];
	int phase, failures = 0, checksDone = 0, ticks = 0;
	ddr_burst4_sram_port u_ddr_burst4_sram_port (.mclk, .sys_rst, .kClk, .kClkN, .readPortSelectN,
		.writePortSelectN, .addr, .writeData, .byteWriteSelectN, .readData, .readDataOe, .readValidFlag);
	link_clock_model u_link_clock_model (.mclk, .sys_rst, .kClk, .kClkN, .phase);
	initial forever #2.5 mclk = !mclk;
	// Hang guard
	always @(posedge mclk) begin
		ticks++;
		if (ticks == 1000) begin
			failures++;
			$display("mismatch %0t run did not finish", $time);
			wrap_up();
		end
	end
	task wrap_up;
		if (failures == 0 && checksDone > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [17:0] got, input logic [17:0] exp);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Drive pins for link edge i, then sample outputs of edge i-1
	task step(input int i, input logic r, input logic w, input logic [5:0] a, input logic [17:0] d,
		input logic [1:0] b);
		do @(posedge mclk); while (phase != (i % 2 ? 5 : 15));
		#1;
		readPortSelectN = r;
		writePortSelectN = w;
		addr = a;
		writeData = d;
		byteWriteSelectN = b;
		repeat (3) @(posedge mclk);
		obs[i] = readData;
		oeSeen[i] = readDataOe;
		vldSeen[i] = readValidFlag;
	endtask
	// Write, dropped repeats, arbitration, lanes, back-to-back reads
	task scen_mixed;
		step(0, 1, 0, 6'h01, 18'h00000, 2'h3);
		step(1, 1, 1, 6'h3F, 18'h00000, 2'h3);
		step(2, 1, 0, 6'h01, 18'h3F000, 2'h0);
		step(3, 1, 1, 6'h3F, 18'h3F001, 2'h0);
		step(4, 0, 0, 6'h01, 18'h3F002, 2'h0);
		step(5, 1, 1, 6'h3F, 18'h3F003, 2'h0);
		step(6, 0, 0, 6'h01, 18'h00000, 2'h3);
		step(7, 1, 1, 6'h3F, 18'h00000, 2'h3);
		step(8, 0, 1, 6'h01, 18'h00FC0, 2'h0);
		step(9, 1, 1, 6'h3F, 18'h00FC1, 2'h2);
		step(10, 1, 1, 6'h3F, 18'h00FC2, 2'h1);
		step(11, 1, 1, 6'h3F, 18'h00FC3, 2'h3);
		for (int i = 12; i < 18; i++) step(i, 1, 1, 6'h3F, 18'h00000, 2'h3);
		for (int i = 1; i < 18; i++) begin
			chk({17'h0, oeSeen[i]}, {17'h0, i > 8 && i < 17});
			chk({17'h0, vldSeen[i]}, {17'h0, i > 7 && i < 16});
		end
		for (int k = 0; k < 4; k++) begin
			chk(obs[9 + k], 18'h3F000 + 18'(k));
			chk(obs[13 + k], ((bt[k][0] ? 18'h3F000 : 18'h00FC0) & 18'h001FF
				| (bt[k][1] ? 18'h3F000 : 18'h00FC0) & 18'h3FE00) + 18'(k));
		end
	endtask
	// Reset, scenario, verdict
	initial begin
		repeat (5) @(posedge mclk);
		#1 sys_rst = 0;
		scen_mixed();
		wrap_up();
	end
endmodule // test_ddr_burst4_sram_port
